// ---- tb_top.sv ----
// Self-checking bench for the serial shift unit
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic       ref_clk_in, rst_in, cpu_wr_in, timer0_ovf_in, global_irq_enable_in;
   logic [1:0] cpu_addr_in;
   logic [7:0] cpu_wdata_in, cpu_rdata_out, b;
   logic [2:0] port_direction_bits_in, port_output_bits_in;
   logic       data_pin_out, data_pin_oe_n_out, do_pin_out, do_pin_oe_n_out, clk_pin_out;
   logic       clk_pin_oe_n_out, port_clk_toggle_out, start_irq_out, overflow_irq_out;
   logic       wake_all_out, wake_idle_out;
   wire        link_clk_in, data_pin_in;
   int         miscompares = 0;
   int         n_checks = 0;
   int         seed = 32'h5fab096f;
   uss_shift_unit uss_shift_unit_i (.*);
   uss_peer uss_peer_i (.data_pin_in(data_pin_out), .data_pin_oe_n_in(data_pin_oe_n_out),
      .clk_pin_in(clk_pin_out), .clk_pin_oe_n_in(clk_pin_oe_n_out),
      .sda_out(data_pin_in), .scl_out(link_clk_in));
   initial begin
      ref_clk_in = 1'b0;
      forever #25 ref_clk_in = ~ref_clk_in;
   end
   function automatic logic [7:0] exp_shift(input logic [7:0] d, input int n, input logic din);
      for (int i = 0; i < n; i++)
         d = {d[6:0], din};
      return d;
   endfunction : exp_shift
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : tally_and_finish
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk_in);
      #1;
   endtask : cyc
   task automatic wrr(input logic [1:0] a, input logic [7:0] d);
      @(posedge ref_clk_in);
      cpu_addr_in <= a;
      cpu_wdata_in <= d;
      cpu_wr_in <= 1'b1;
      @(posedge ref_clk_in);
      cpu_wr_in <= 1'b0;
   endtask : wrr
   task automatic rdc(input logic [1:0] a, input logic [7:0] m, input logic [7:0] e,
                      input string nm);
      @(posedge ref_clk_in);
      cpu_addr_in <= a;
      cyc(1);
      chk(nm, cpu_rdata_out & m, e);
   endtask : rdc
   initial begin
      #2000000;
      miscompares++;
      tally_and_finish();
   end
   initial begin
      rst_in = 1'b1;
      cpu_addr_in = 2'h0;
      cpu_wr_in = 1'b0;
      cpu_wdata_in = 8'h00;
      timer0_ovf_in = 1'b0;
      global_irq_enable_in = 1'b0;
      port_direction_bits_in = 3'h0;
      port_output_bits_in = 3'h7;
      // Link clock runs during reset so the link-side flops clear
      fork
         uss_peer_i.wake(8);
      join_none
      cyc(20);
      chk("rst_rdata", cpu_rdata_out, 8'h00);
      @(posedge ref_clk_in);
      rst_in <= 1'b0;
      // Two link edges pass before the link side leaves reset
      uss_peer_i.wake(3);
      for (int i = 0; i < 4; i++)
         rdc(2'(i), 8'hFF, (i == 1) ? 8'h10 : 8'h00, "reset_reg");
      b = $random(seed);
      wrr(0, b);
      wrr(1, 8'h0E);
      wrr(2, 8'h02);
      wrr(2, 8'h02);
      rdc(0, 8'hFF, exp_shift(b, 2, 1'b1), "soft_data");
      rdc(1, 8'hEF, 8'h40, "soft_status");
      global_irq_enable_in <= 1'b1;
      wrr(2, 8'h40);
      cyc(2);
      chk("ovf_irq", {6'h0, overflow_irq_out, wake_idle_out}, 8'h03);
      global_irq_enable_in <= 1'b0;
      cyc(2);
      chk("gie_off", {6'h0, overflow_irq_out, wake_idle_out}, 8'h00);
      wrr(1, 8'h40);
      rdc(1, 8'hEF, 8'h00, "ovf_clear");
      wrr(2, 8'h04);
      repeat (3) begin
         @(posedge ref_clk_in);
         timer0_ovf_in <= 1'b1;
         @(posedge ref_clk_in);
         timer0_ovf_in <= 1'b0;
      end
      b = $random(seed);
      @(posedge ref_clk_in);
      cpu_addr_in <= 2'h0;
      cpu_wdata_in <= b;
      cpu_wr_in <= 1'b1;
      timer0_ovf_in <= 1'b1;
      @(posedge ref_clk_in);
      cpu_wr_in <= 1'b0;
      timer0_ovf_in <= 1'b0;
      rdc(0, 8'hFF, b, "write_wins");
      rdc(1, 8'h0F, 8'h04, "timer_count");
      wrr(1, 8'h00);
      wrr(2, 8'h08);
      b = $random(seed);
      uss_peer_i.send_byte(b);
      cyc(8);
      rdc(0, 8'hFF, b, "ext_data");
      rdc(1, 8'hEF, 8'hC0, "ext_status");
      wrr(1, 8'hC0);
      wrr(2, 8'h0B);
      rdc(1, 8'h8F, 8'h01, "toggle_count");
      rdc(2, 8'hFF, 8'h0A, "ctrl_read");
      wrr(1, 8'hE0);
      port_direction_bits_in <= 3'b101;
      wrr(0, 8'hFF);
      wrr(2, 8'hA8);
      global_irq_enable_in <= 1'b1;
      uss_peer_i.start_cond();
      cyc(8);
      chk("start_hold", {5'h0, start_irq_out, wake_all_out, clk_pin_oe_n_out}, 8'h06);
      rdc(1, 8'hA0, 8'h80, "start_flag");
      wrr(1, 8'h80);
      cyc(3);
      chk("start_release", {6'h0, start_irq_out, clk_pin_oe_n_out}, 8'h01);
      uss_peer_i.set_sda(1'b0);
      rdc(1, 8'h10, 8'h10, "collision");
      uss_peer_i.set_sda(1'b1);
      wrr(0, 8'h00);
      cyc(5);
      chk("sda_pull", {6'h0, data_pin_out, data_pin_oe_n_out}, 8'h00);
      rdc(1, 8'h10, 8'h00, "no_collision");
      wrr(0, 8'hFF);
      uss_peer_i.stop_cond();
      rdc(1, 8'hA0, 8'h20, "stop_flag");
      chk("stop_no_irq", {6'h0, start_irq_out, overflow_irq_out}, 8'h00);
      wrr(2, 8'h10);
      port_direction_bits_in <= 3'b010;
      wrr(0, 8'h80);
      cyc(2);
      chk("do_drive", {6'h0, do_pin_out, do_pin_oe_n_out}, 8'h02);
      port_direction_bits_in <= 3'b000;
      cyc(3);
      chk("do_release", {7'h0, do_pin_oe_n_out}, 8'h01);
      tally_and_finish();
   end
endmodule : tb_top
`default_nettype wire

// ---- uss_peer.sv ----
// Serial peer model driving the link clock and data line
`timescale 1ns/1ps
`default_nettype none
module uss_peer (
   input  wire logic data_pin_in,
   input  wire logic data_pin_oe_n_in,
   input  wire logic clk_pin_in,
   input  wire logic clk_pin_oe_n_in,
   output wire logic sda_out,
   output wire logic scl_out
);
   logic base_clk;
   logic sda_q;
   logic scl_q;
   initial begin
      base_clk = 1'b0;
      sda_q = 1'b1;
      scl_q = 1'b0;
      #7;
      forever #15 base_clk = ~base_clk;
   end
   // Pulled-up lines, low if any party pulls
   assign sda_out = sda_q & (data_pin_oe_n_in | data_pin_in);
   assign scl_out = scl_q & (clk_pin_oe_n_in | clk_pin_in);
   // Half period of 16 peer clocks, 480 ns or close to ten system clock periods
   task automatic half;
      repeat (16) @(posedge base_clk);
   endtask : half
   // Short clock pulses that let the link-side reset take effect
   task automatic wake(input int n);
      repeat (2 * n) begin
         repeat (2) @(posedge base_clk);
         scl_q <= ~scl_q;
      end
   endtask : wake
   task automatic set_sda(input logic v);
      half();
      sda_q <= v;
      half();
   endtask : set_sda
   task automatic send_byte(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         half();
         sda_q <= b[i];
         half();
         scl_q <= 1'b1;
         half();
         scl_q <= 1'b0;
      end
   endtask : send_byte
   task automatic start_cond;
      half();
      scl_q <= 1'b1;
      half();
      sda_q <= 1'b0;
      half();
      scl_q <= 1'b0;
      half();
   endtask : start_cond
   task automatic stop_cond;
      half();
      sda_q <= 1'b0;
      half();
      scl_q <= 1'b1;
      half();
      sda_q <= 1'b1;
      half();
   endtask : stop_cond
endmodule : uss_peer
`default_nettype wire

// ---- uss_pkg.sv ----
// Constants, register layouts and pin bundle for the universal serial shift unit
package uss_pkg;

   // Register selects on the CPU register port
   localparam logic [1:0] REG_DATA    = 2'h0;
   localparam logic [1:0] REG_STATUS  = 2'h1;
   localparam logic [1:0] REG_CONTROL = 2'h2;

   // Wire mode settings
   localparam logic [1:0] WM_OFF      = 2'h0;
   localparam logic [1:0] WM_THREE    = 2'h1;
   localparam logic [1:0] WM_TWO      = 2'h2;
   localparam logic [1:0] WM_TWO_HOLD = 2'h3;

   // Clock source settings
   localparam logic [1:0] CS_SOFT     = 2'h0;
   localparam logic [1:0] CS_TIMER    = 2'h1;
   localparam logic [1:0] CS_EXT_POS  = 2'h2;
   localparam logic [1:0] CS_EXT_NEG  = 2'h3;

   // Reset values and counter limits
   localparam logic [7:0] DATA_RST    = 8'h00;
   localparam logic [7:0] CTRL_RST    = 8'h00;
   localparam logic [3:0] CNT_RST     = 4'h0;
   localparam logic [3:0] CNT_MAX     = 4'hF;
   localparam logic [3:0] CNT_ONE     = 4'h1;
   localparam logic [7:0] READ_ZERO   = 8'h00;

   // Port bit positions of the three serial pins
   localparam int PIN_DATA = 0;
   localparam int PIN_DO   = 1;
   localparam int PIN_CLK  = 2;

   // Synchroniser depth
   localparam int SYNC_DEPTH = 3;

   typedef struct packed {
      logic       start_irq_enable;
      logic       overflow_irq_enable;
      logic [1:0] wire_mode_select;
      logic [1:0] clock_source_select;
      logic       clock_strobe_bit;
      logic       toggle_clock_strobe;
   } uss_ctrl_s;

   typedef struct packed {
      logic       start_flag;
      logic       overflow_flag;
      logic       stop_flag;
      logic       collision_bit;
      logic [3:0] bit_counter;
   } uss_stat_s;

   typedef struct packed {
      logic data_out;
      logic data_oe_n;
      logic do_out;
      logic do_oe_n;
      logic clk_out;
      logic clk_oe_n;
   } uss_pins_s;

endpackage : uss_pkg

// ---- uss_shift_unit.sv ----
// Universal serial shift unit: shift register, edge counter, start/stop detect, pin drive
`timescale 1ns/1ps
`default_nettype none

module uss_sync3 #(
   parameter int   DEPTH     = 3,
   parameter logic RST_LEVEL = 1'b0
) (
   input  wire logic ref_clk_in,
   input  wire logic rst_in,
   input  wire logic async_in,
   output var  logic level_out,
   output logic      change_out
);
   logic [DEPTH-1:0] stage_q;
   logic             level_q;
   if (DEPTH != 3) begin : g_depth_chk
      $error("uss_sync3 supports a depth of three only");
   end
   // Reset to the pin's idle level so release shows no false edge
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         stage_q <= {DEPTH{RST_LEVEL}};
      end else begin
         stage_q <= {stage_q[DEPTH-2:0], async_in};
      end
   end
   // Change counts once the last two stages agree
   assign change_out = (stage_q[1] == stage_q[2]) && (stage_q[2] != level_q);
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         level_q <= RST_LEVEL;
      end else if (change_out) begin
         level_q <= stage_q[2];
      end
   end
   assign level_out = level_q;
endmodule : uss_sync3

module uss_shift_unit #(
   parameter int DATA_W = 8
) (
   input  wire logic       ref_clk_in,
   input  wire logic       rst_in,
   input  wire logic       link_clk_in,
   input  wire logic [1:0] cpu_addr_in,
   input  wire logic       cpu_wr_in,
   input  wire logic [7:0] cpu_wdata_in,
   output var  logic [7:0] cpu_rdata_out,
   input  wire logic       timer0_ovf_in,
   input  wire logic       global_irq_enable_in,
   input  wire logic [2:0] port_direction_bits_in,
   input  wire logic [2:0] port_output_bits_in,
   input  wire logic       data_pin_in,
   output var  logic       data_pin_out,
   output var  logic       data_pin_oe_n_out,
   output var  logic       do_pin_out,
   output var  logic       do_pin_oe_n_out,
   output var  logic       clk_pin_out,
   output var  logic       clk_pin_oe_n_out,
   output var  logic       port_clk_toggle_out,
   output var  logic       start_irq_out,
   output var  logic       overflow_irq_out,
   output var  logic       wake_all_out,
   output var  logic       wake_idle_out
);
   if (DATA_W != 8) begin : g_width_chk
      $error("uss_shift_unit supports an eight-bit data register only");
   end
   uss_pkg::uss_ctrl_s ctrl_q;
   uss_pkg::uss_ctrl_s ctrl_w;
   uss_pkg::uss_stat_s stat_w;
   uss_pkg::uss_pins_s pins_d;
   uss_pkg::uss_pins_s pins_q;
   logic [DATA_W-1:0]  shift_q;
   logic [3:0]         cnt_q;
   logic               start_q;
   logic               ovf_q;
   logic               stop_q;
   logic               hold_bit_q;
   logic               do_bit;
   logic               latch_open;

   // Link-domain reset and edge toggles
   logic [1:0] link_rst_q;
   logic       rise_tog_q;
   logic       fall_tog_q;
   always_ff @(posedge link_clk_in) begin
      link_rst_q <= {link_rst_q[0], rst_in};
   end
   always_ff @(posedge link_clk_in) begin
      if (link_rst_q[1]) begin
         rise_tog_q <= 1'b0;
      end else begin
         rise_tog_q <= ~rise_tog_q;
      end
   end
   always_ff @(negedge link_clk_in) begin
      if (link_rst_q[1]) begin
         fall_tog_q <= 1'b0;
      end else begin
         fall_tog_q <= ~fall_tog_q;
      end
   end

   // Crossings into the system clock domain
   logic rise_ev;
   logic fall_ev;
   logic data_lvl;
   logic data_chg;
   logic clk_lvl;
   uss_sync3 #(.DEPTH(uss_pkg::SYNC_DEPTH)) u_rise_sync (
      .ref_clk_in (ref_clk_in),
      .rst_in     (rst_in),
      .async_in   (rise_tog_q),
      .level_out  (),
      .change_out (rise_ev)
   );
   uss_sync3 #(.DEPTH(uss_pkg::SYNC_DEPTH)) u_fall_sync (
      .ref_clk_in (ref_clk_in),
      .rst_in     (rst_in),
      .async_in   (fall_tog_q),
      .level_out  (),
      .change_out (fall_ev)
   );
   // Data line idles high behind its pull-up
   uss_sync3 #(.DEPTH(uss_pkg::SYNC_DEPTH), .RST_LEVEL(1'b1)) u_data_sync (
      .ref_clk_in (ref_clk_in),
      .rst_in     (rst_in),
      .async_in   (data_pin_in),
      .level_out  (data_lvl),
      .change_out (data_chg)
   );
   uss_sync3 #(.DEPTH(uss_pkg::SYNC_DEPTH)) u_clk_sync (
      .ref_clk_in (ref_clk_in),
      .rst_in     (rst_in),
      .async_in   (link_clk_in),
      .level_out  (clk_lvl),
      .change_out ()
   );

   // Register port decode
   logic wr_data;
   logic wr_stat;
   logic wr_ctrl;
   assign wr_data = cpu_wr_in && (cpu_addr_in == uss_pkg::REG_DATA);
   assign wr_stat = cpu_wr_in && (cpu_addr_in == uss_pkg::REG_STATUS);
   assign wr_ctrl = cpu_wr_in && (cpu_addr_in == uss_pkg::REG_CONTROL);
   assign ctrl_w  = uss_pkg::uss_ctrl_s'(cpu_wdata_in);
   assign stat_w  = uss_pkg::uss_stat_s'(cpu_wdata_in);
   // Clock source selection
   logic ext_src;
   logic ext_edge;
   logic soft_strobe;
   logic toggle_strobe;
   logic timer_tick;
   logic shift_clk;
   logic cnt_clk;
   logic two_wire;
   assign ext_src       = ctrl_q.clock_source_select[1];
   assign ext_edge      = ctrl_q.clock_source_select[0] ? fall_ev : rise_ev;
   assign soft_strobe   = wr_ctrl && ctrl_w.clock_strobe_bit
                          && (ctrl_w.clock_source_select == uss_pkg::CS_SOFT);
   assign toggle_strobe = wr_ctrl && ctrl_w.toggle_clock_strobe && ctrl_w.clock_strobe_bit
                          && ctrl_w.clock_source_select[1];
   assign timer_tick    = timer0_ovf_in
                          && (ctrl_q.clock_source_select == uss_pkg::CS_TIMER);
   // Separate shift and counter clocks; wire mode plays no part here
   assign shift_clk     = soft_strobe || timer_tick || (ext_src && ext_edge);
   assign cnt_clk       = soft_strobe || timer_tick || toggle_strobe
                          || (ext_src && !ctrl_q.clock_strobe_bit && (rise_ev || fall_ev));
   assign two_wire      = ctrl_q.wire_mode_select[1];

   // Control register
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         ctrl_q <= uss_pkg::uss_ctrl_s'(uss_pkg::CTRL_RST);
      end else if (wr_ctrl) begin
         ctrl_q <= ctrl_w;
         ctrl_q.toggle_clock_strobe <= 1'b0;
      end
   end

   // Shift register: CPU write wins over a shift
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         shift_q <= uss_pkg::DATA_RST;
      end else if (wr_data) begin
         shift_q <= cpu_wdata_in;
      end else if (shift_clk) begin
         shift_q <= {shift_q[DATA_W-2:0], data_lvl};
      end
   end

   // Edge counter
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         cnt_q <= uss_pkg::CNT_RST;
      end else if (wr_stat) begin
         cnt_q <= stat_w.bit_counter;
      end else if (cnt_clk) begin
         cnt_q <= 4'(cnt_q + uss_pkg::CNT_ONE);
      end
   end

   // Overflow flag, a status write beats set
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         ovf_q <= 1'b0;
      end else if (cnt_clk && !wr_stat && (cnt_q == uss_pkg::CNT_MAX)) begin
         ovf_q <= 1'b1;
      end else if (wr_stat && stat_w.overflow_flag) begin
         ovf_q <= 1'b0;
      end
   end

   // Start and stop detection on synchronised levels
   logic start_cond;
   logic stop_cond;
   logic clk_edge_start;
   // During a change the held level is still the old one
   assign start_cond     = two_wire && data_chg && data_lvl && clk_lvl;
   assign stop_cond      = two_wire && data_chg && !data_lvl && clk_lvl;
   assign clk_edge_start = !two_wire && ext_src && !ctrl_q.clock_strobe_bit
                           && (rise_ev || fall_ev);

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         start_q <= 1'b0;
      end else if (start_cond || clk_edge_start) begin
         start_q <= 1'b1;
      end else if (wr_stat && stat_w.start_flag) begin
         start_q <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         stop_q <= 1'b0;
      end else if (stop_cond) begin
         stop_q <= 1'b1;
      end else if (wr_stat && stat_w.stop_flag) begin
         stop_q <= 1'b0;
      end
   end

   // Output latch, open in the half opposite the sampling edge
   assign latch_open = !ext_src
                       || (ctrl_q.clock_source_select[0] ? clk_lvl : !clk_lvl);
   assign do_bit     = latch_open ? shift_q[DATA_W-1] : hold_bit_q;
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         hold_bit_q <= 1'b0;
      end else begin
         hold_bit_q <= do_bit;
      end
   end
   // Pin drive per wire mode; enables low while driving
   logic clk_hold;
   logic sda_low;
   logic scl_low;
   assign clk_hold = start_q
                     || ((ctrl_q.wire_mode_select == uss_pkg::WM_TWO_HOLD) && ovf_q);
   assign sda_low  = !do_bit || !port_output_bits_in[uss_pkg::PIN_DATA];
   assign scl_low  = !port_output_bits_in[uss_pkg::PIN_CLK] || clk_hold;
   always_comb begin
      pins_d = '{data_out: 1'b1, data_oe_n: 1'b1, do_out: 1'b0, do_oe_n: 1'b1,
                 clk_out: 1'b1, clk_oe_n: 1'b1};
      case (ctrl_q.wire_mode_select)
         uss_pkg::WM_THREE: begin
            pins_d.do_out  = do_bit;
            pins_d.do_oe_n = !port_direction_bits_in[uss_pkg::PIN_DO];
         end
         uss_pkg::WM_TWO, uss_pkg::WM_TWO_HOLD: begin
            pins_d.data_out  = 1'b0;
            pins_d.data_oe_n = !(port_direction_bits_in[uss_pkg::PIN_DATA] && sda_low);
            pins_d.clk_out   = 1'b0;
            pins_d.clk_oe_n  = !(port_direction_bits_in[uss_pkg::PIN_CLK] && scl_low);
         end
         default: begin
            pins_d.do_oe_n = 1'b1;
         end
      endcase
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         pins_q <= '{data_out: 1'b1, data_oe_n: 1'b1, do_out: 1'b0, do_oe_n: 1'b1,
                     clk_out: 1'b1, clk_oe_n: 1'b1};
      end else begin
         pins_q <= pins_d;
      end
   end

   assign data_pin_out      = pins_q.data_out;
   assign data_pin_oe_n_out = pins_q.data_oe_n;
   assign do_pin_out        = pins_q.do_out;
   assign do_pin_oe_n_out   = pins_q.do_oe_n;
   assign clk_pin_out       = pins_q.clk_out;
   assign clk_pin_oe_n_out  = pins_q.clk_oe_n;

   // Requests and wake-ups follow enables without delay beyond one flop
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         start_irq_out       <= 1'b0;
         overflow_irq_out    <= 1'b0;
         wake_all_out        <= 1'b0;
         wake_idle_out       <= 1'b0;
         port_clk_toggle_out <= 1'b0;
      end else begin
         start_irq_out       <= start_q && ctrl_q.start_irq_enable
                                && global_irq_enable_in;
         overflow_irq_out    <= ovf_q && ctrl_q.overflow_irq_enable
                                && global_irq_enable_in;
         wake_all_out        <= start_q && ctrl_q.start_irq_enable
                                && global_irq_enable_in;
         wake_idle_out       <= global_irq_enable_in
                                && ((start_q && ctrl_q.start_irq_enable)
                                || (ovf_q && ctrl_q.overflow_irq_enable));
         port_clk_toggle_out <= wr_ctrl && ctrl_w.toggle_clock_strobe;
      end
   end

   // Read data, one cycle after the address
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         cpu_rdata_out <= uss_pkg::READ_ZERO;
      end else begin
         case (cpu_addr_in)
            uss_pkg::REG_DATA:    cpu_rdata_out <= shift_q;
            uss_pkg::REG_STATUS:  cpu_rdata_out <= {start_q, ovf_q, stop_q,
                                                    shift_q[DATA_W-1] != data_lvl, cnt_q};
            uss_pkg::REG_CONTROL: cpu_rdata_out <= {ctrl_q[7:1], 1'b0};
            default:              cpu_rdata_out <= uss_pkg::READ_ZERO;
         endcase
      end
   end

endmodule : uss_shift_unit

`default_nettype wire

// ---- uss_shift_unit_checker.sv ----
// Port-level assertions for the serial shift unit
`timescale 1ns/1ps
`default_nettype none
module uss_shift_unit_checker (
   input wire logic       ref_clk_in,
   input wire logic       rst_in,
   input wire logic [1:0] cpu_addr_in,
   input wire logic       cpu_wr_in,
   input wire logic [7:0] cpu_wdata_in,
   input wire logic [7:0] cpu_rdata_out,
   input wire logic       global_irq_enable_in,
   input wire logic [2:0] port_direction_bits_in,
   input wire logic       data_pin_out,
   input wire logic       data_pin_oe_n_out,
   input wire logic       do_pin_oe_n_out,
   input wire logic       clk_pin_out,
   input wire logic       clk_pin_oe_n_out,
   input wire logic       port_clk_toggle_out,
   input wire logic       start_irq_out,
   input wire logic       overflow_irq_out,
   input wire logic       wake_all_out,
   input wire logic       wake_idle_out
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);
   logic tgl_req;
   // Control write carrying the toggle strobe
   assign tgl_req = cpu_wr_in & (cpu_addr_in == uss_pkg::REG_CONTROL) & cpu_wdata_in[0];
   property p_unmapped; cpu_addr_in == 2'h3 |=> cpu_rdata_out == 8'h00; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_tgl_read; cpu_addr_in == uss_pkg::REG_CONTROL |=> !cpu_rdata_out[0]; endproperty
   a_tgl_read: assert property (p_tgl_read) else $error("toggle bit read back");
   property p_tgl_set; tgl_req |=> port_clk_toggle_out; endproperty
   a_tgl_set: assert property (p_tgl_set) else $error("toggle pulse missing");
   property p_tgl_only; port_clk_toggle_out |-> $past(tgl_req); endproperty
   a_tgl_only: assert property (p_tgl_only) else $error("toggle pulse without cause");
   property p_gie; !global_irq_enable_in |=> !start_irq_out && !overflow_irq_out; endproperty
   a_gie: assert property (p_gie) else $error("request with global off");
   property p_wake_all; wake_all_out == start_irq_out; endproperty
   a_wake_all: assert property (p_wake_all) else $error("wake all mismatch");
   property p_wake_idle; wake_idle_out == (start_irq_out | overflow_irq_out); endproperty
   a_wake_idle: assert property (p_wake_idle) else $error("wake idle mismatch");
   property p_do_dir; !port_direction_bits_in[1] |=> do_pin_oe_n_out; endproperty
   a_do_dir: assert property (p_do_dir) else $error("output pin driven as input");
   property p_clk_dir; !port_direction_bits_in[2] |=> clk_pin_oe_n_out; endproperty
   a_clk_dir: assert property (p_clk_dir) else $error("clock pin driven as input");
   property p_sda_od; !data_pin_oe_n_out |-> !data_pin_out; endproperty
   a_sda_od: assert property (p_sda_od) else $error("data line driven high");
   property p_scl_od; !clk_pin_oe_n_out |-> !clk_pin_out; endproperty
   a_scl_od: assert property (p_scl_od) else $error("clock line driven high");
   c_start: cover property (start_irq_out);
   c_ovf: cover property (overflow_irq_out);
   c_tgl: cover property (port_clk_toggle_out);
   c_hold: cover property (!clk_pin_oe_n_out);
endmodule : uss_shift_unit_checker
bind uss_shift_unit uss_shift_unit_checker uss_shift_unit_checker_i (.*);
`default_nettype wire
